// >>> shared/com_pkg.sv
// Purpose: shared constants and types for the cabinet option menu control
// Assumes: 10 MHz clk_sys, APB register access, one prescaled tick
// Notes: times are kept in their own unit, cycle and tick counts derive from them, except SLOW_BLINK_TICKS, given in ticks
package com_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;

    localparam int unsigned HOLD_S = 5;
    localparam int unsigned ALARM_DELAY_S = 10;
    localparam int unsigned TONE_CONT_S = 30;
    localparam int unsigned TONE_REP_S = 10;
    localparam int unsigned SB_MIN_MINUTES = 15;
    localparam int unsigned SLOW_BLINK_TICKS = 5;

    localparam logic [5:0] HOLD_TICKS = 6'(HOLD_S * TICKS_PER_S);
    localparam logic [6:0] ALARM_DELAY_TICKS = 7'(ALARM_DELAY_S * TICKS_PER_S);
    localparam logic [8:0] TONE_CONT_TICKS = 9'(TONE_CONT_S * TICKS_PER_S);
    localparam logic [6:0] TONE_REP_TICKS = 7'(TONE_REP_S * TICKS_PER_S);
    localparam logic [9:0] MINUTE_TICKS = 10'(60 * TICKS_PER_S);
    localparam logic [7:0] SB_MIN_SET = 8'(SB_MIN_MINUTES);

    localparam int unsigned NUM_OPT = 7;
    localparam int unsigned OPT_PWD = 0;
    localparam int unsigned OPT_UVANY = 1;
    localparam int unsigned OPT_MANUAL = 2;
    localparam int unsigned OPT_SETBACK = 3;
    localparam int unsigned OPT_MONOFF = 4;
    localparam int unsigned OPT_TEMPSB = 5;
    localparam int unsigned OPT_SILENCE = 6;

    localparam logic [11:0] ADDR_OPT = 12'h000;
    localparam logic [11:0] ADDR_PWD = 12'h004;
    localparam logic [11:0] ADDR_SBTIME = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;

    localparam logic [6:0] OPT_RST = 7'h00;
    localparam logic [5:0] PWD_RST = 6'h04;
    localparam logic [7:0] SBTIME_RST = 8'h1e;

    localparam logic [1:0] CODE_BLOWER = 2'h0;
    localparam logic [1:0] CODE_HIDDEN = 2'h1;
    localparam logic [1:0] CODE_UP = 2'h2;
    localparam logic [1:0] CODE_DOWN = 2'h3;

    typedef struct packed {
        logic blower;
        logic light;
        logic uv;
        logic outlet;
        logic up;
        logic down;
        logic hidden;
    } com_keys_t;

    typedef struct packed {
        logic winClosed;
        logic winNormal;
        logic airLow;
        logic airHigh;
        logic wasRunning;
    } com_sense_t;

    typedef enum logic [1:0] {
        COM_RUN = 2'b01,
        COM_MENU = 2'b10
    } com_mode_t;

endpackage : com_pkg

// >>> hdl/com_sync.sv
// Purpose: two-flop synchroniser for panel and switch pins
// Assumes: pins are slow levels, no bus coherence needed
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
`default_nettype none
module com_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : com_sync
`default_nettype wire

// >>> hdl/com_tick.sv
// Purpose: prescaler giving the base tick and the two blink phases
// Assumes: CYC of at least two
// Notes: shorten CYC in simulation, every slow timer scales with it
`timescale 1ns/100ps
`default_nettype none
module com_tick
    import com_pkg::*;
#(
    parameter int unsigned CYC = TICK_CYC_DEF
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset, active low
    output logic tick, // one-cycle pulse per tick
    output logic fastBlink, // toggles each tick
    output logic slowBlink // toggles every few ticks
);
    localparam int CW = $clog2(CYC);
    logic [CW-1:0] cnt;
    logic [2:0] slowCnt;
    wire cntEnd = (cnt == CW'(CYC - 1));
    wire slowEnd = (slowCnt == 3'(SLOW_BLINK_TICKS - 1));

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            tick <= 1'b0;
            fastBlink <= 1'b0;
            slowBlink <= 1'b0;
            slowCnt <= '0;
        end
        else
        begin
            cnt <= cntEnd ? '0 : cnt + 1'b1;
            tick <= cntEnd;
            if (tick)
            begin
                fastBlink <= ~fastBlink;
                slowCnt <= slowEnd ? '0 : slowCnt + 1'b1;
                if (slowEnd)
                    slowBlink <= ~slowBlink;
            end
        end
    end
endmodule : com_tick
`default_nettype wire

// >>> hdl/com_ctrl.sv
// Purpose: option menu, blower, light, uv, alarm and relay control
// Assumes: keys and switches are debounced levels from the panel
// Notes: registers over APB answer with one flop stage, no wait states
`timescale 1ns/100ps
`default_nettype none
module com_ctrl
    import com_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire com_keys_t keyPin, // panel keys, high when pressed
    input wire com_sense_t sensePin, // window, airflow and restart pins
    output logic menuLed, // red indicator above blower key
    output logic [NUM_OPT-1:0] airflowBarDisplay, // green segments
    output logic blowerLed, // green indicator above blower key
    output logic lightLed, // blue indicator above light key
    output logic blowerOn, // blower drive
    output logic blowerSlow, // reduced setback speed
    output logic lightOn, // work light drive
    output logic uvOn, // uv lamp drive
    output logic fanRelay, // fan contact
    output logic alarmRelay, // alarm contact
    output logic auxDcEn, // auxiliary dc output
    output logic beeper // audible tone
);
    com_keys_t keyS, keyPrev, keyPress;
    com_sense_t sense;
    logic tick, fastBlink, slowBlink;

    com_sync #(.W($bits(com_keys_t))) u_keySync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(keyPin),
        .q(keyS)
    );

    com_sync #(.W($bits(com_sense_t))) u_senseSync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(sensePin),
        .q(sense)
    );

    com_tick #(.CYC(TICK_CYCLES)) u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick),
        .fastBlink(fastBlink),
        .slowBlink(slowBlink)
    );

    com_mode_t mode;
    logic [NUM_OPT-1:0] opts, pending;
    logic [2:0] sel;
    logic [1:0] entryStep;
    logic [5:0] pwdReg, pwdShift;
    logic [7:0] sbTimeReg, sbMin;
    logic [9:0] minCnt;
    logic [5:0] holdCnt;
    logic armStop, booted, uvReq, lightLockOff, tempSb, alarmOn;
    logic [6:0] persistCnt, repCnt;
    logic [8:0] toneCnt;
    logic clickOn;

    assign keyPress = keyS & ~keyPrev;
    wire inRun = (mode == COM_RUN);
    wire inMenu = (mode == COM_MENU);
    wire anyPress = |keyPress;

    // menu entry: hold outlet key, then hidden, up, down
    wire entryKey = (entryStep == 2'h0) ? keyPress.hidden :
                    (entryStep == 2'h1) ? keyPress.up : keyPress.down;
    wire entryDone = inRun & keyS.outlet & entryKey & (entryStep == 2'h2);
    wire entryMiss = ~keyS.outlet | (anyPress & ~keyPress.outlet & ~entryKey);

    // password keys are encoded two bits each, oldest first
    wire codeKey = keyPress.blower | keyPress.hidden | keyPress.up | keyPress.down;
    wire [1:0] code = keyPress.blower ? CODE_BLOWER :
                      keyPress.hidden ? CODE_HIDDEN :
                      keyPress.up ? CODE_UP : CODE_DOWN;
    wire [5:0] next_pwdShift = {pwdShift[3:0], code};
    wire pwdMatch = codeKey & keyPress.blower & (next_pwdShift == pwdReg);

    wire holdFull = (holdCnt == HOLD_TICKS);
    wire holdHit = tick & keyS.blower & (holdCnt == HOLD_TICKS - 6'h01);
    wire blowerRel = keyPrev.blower & ~keyS.blower;
    wire bootStart = ~booted & tick & sense.wasRunning & ~opts[OPT_MANUAL];
    wire manStart = opts[OPT_PWD] ? pwdMatch : keyPress.blower;
    wire startReq = ~blowerOn & (bootStart | (inRun & manStart));
    wire stopReq = blowerOn & inRun & blowerRel & armStop & ~holdFull;

    // setback states
    wire sbActive = opts[OPT_SETBACK] & blowerOn & sense.winClosed;
    wire tempOk = opts[OPT_TEMPSB] & opts[OPT_SETBACK] & opts[OPT_PWD]
                  & sense.winNormal & blowerOn & (sbTimeReg >= SB_MIN_SET);
    wire minEnd = tick & (minCnt == MINUTE_TICKS - 10'h001);
    wire sbTimeout = tempSb & (sbMin == sbTimeReg);

    wire uvPermit = sense.winClosed | opts[OPT_UVANY];

    // airflow alarm
    wire alarmCond = ~opts[OPT_MONOFF] & blowerOn & (sense.airLow | sense.airHigh);
    wire alarmRaise = tick & alarmCond & (persistCnt == ALARM_DELAY_TICKS - 7'h01);
    wire toneCont = toneCnt < TONE_CONT_TICKS;
    wire toneReq = alarmOn & (toneCont | (repCnt == 7'h00));
    wire mute = opts[OPT_SILENCE] & inRun;

    // menu editing
    wire [2:0] selMax = 3'(NUM_OPT - 1);
    wire selLeft = inMenu & keyPress.uv & (sel != 3'h0);
    wire selRight = inMenu & keyPress.outlet & (sel != selMax);
    wire commit = inMenu & keyPress.hidden;
    wire abort = inMenu & ~keyPress.hidden & keyPress.light;

    // apb decode
    wire apbSetup = psel & ~penable;
    wire apbWr = psel & penable & pready & pwrite;
    wire hitOpt = (paddr == ADDR_OPT);
    wire hitPwd = (paddr == ADDR_PWD);
    wire hitSbt = (paddr == ADDR_SBTIME);
    wire hitSts = (paddr == ADDR_STATUS);
    wire hitAny = hitOpt | hitPwd | hitSbt | hitSts;
    wire [31:0] statusWord = {17'h00000, pending, uvOn, lightOn, sbActive, tempSb,
                              alarmOn, blowerSlow, blowerOn, inMenu};
    wire [31:0] rdMux = hitOpt ? {25'h0000000, opts} :
                        hitPwd ? {26'h0000000, pwdReg} :
                        hitSbt ? {24'h000000, sbTimeReg} :
                        hitSts ? statusWord : 32'h00000000;

    // indicator selection
    wire next_blowerSlow = blowerOn & (sbActive | tempSb);
    wire [NUM_OPT-1:0] menuSegs;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OPT; gi++)
        begin : g_seg
            wire isSel = (sel == 3'(gi));
            wire blinkPh = pending[gi] ? fastBlink : slowBlink;
            assign menuSegs[gi] = isSel ? blinkPh : pending[gi];
        end
    endgenerate
    wire [NUM_OPT-1:0] runSegs = ~blowerOn ? '0 :
                                 next_blowerSlow ? {NUM_OPT{slowBlink}} : '1;
    wire next_blowerLed = blowerOn & (next_blowerSlow ? slowBlink : 1'b1);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            keyPrev <= '0;
            mode <= COM_RUN;
            entryStep <= 2'h0;
            sel <= 3'h0;
            pending <= OPT_RST;
        end
        else
        begin
            keyPrev <= keyS;
            case (mode)
                COM_RUN:
                begin
                    if (entryDone)
                    begin
                        mode <= COM_MENU;
                        pending <= opts;
                        sel <= 3'h0;
                        entryStep <= 2'h0;
                    end
                    else if (entryMiss)
                        entryStep <= 2'h0;
                    else if (entryKey)
                        entryStep <= entryStep + 2'h1;
                end
                COM_MENU:
                begin
                    if (commit | abort)
                        mode <= COM_RUN;
                    if (selLeft)
                        sel <= sel - 3'h1;
                    else if (selRight)
                        sel <= sel + 3'h1;
                    if (keyPress.up)
                        pending[sel] <= 1'b1;
                    else if (keyPress.down)
                        pending[sel] <= 1'b0;
                end
                default:
                    mode <= COM_RUN;
            endcase
        end
    end

    // option store: menu commit wins over a software write in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            opts <= OPT_RST;
            pwdReg <= PWD_RST;
            sbTimeReg <= SBTIME_RST;
        end
        else
        begin
            if (commit)
                opts <= pending;
            else if (apbWr & hitOpt)
                opts <= pwdata[NUM_OPT-1:0];
            if (apbWr & hitPwd)
                pwdReg <= pwdata[5:0];
            if (apbWr & hitSbt)
                sbTimeReg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= apbSetup;
            pslverr <= apbSetup & ~hitAny;
            prdata <= (apbSetup & ~pwrite) ? rdMux : 32'h00000000;
        end
    end

    // blower, password and temporary setback
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            blowerOn <= 1'b0;
            booted <= 1'b0;
            armStop <= 1'b0;
            holdCnt <= 6'h00;
            pwdShift <= 6'h3f;
            tempSb <= 1'b0;
            minCnt <= 10'h000;
            sbMin <= 8'h00;
        end
        else
        begin
            if (tick)
                booted <= 1'b1;
            if (startReq)
                blowerOn <= 1'b1;
            else if (stopReq)
                blowerOn <= 1'b0;
            // a release only stops the blower if the press found it running
            if (keyPress.blower)
                armStop <= blowerOn;
            else if (blowerRel)
                armStop <= 1'b0;
            if (~keyS.blower)
                holdCnt <= 6'h00;
            else if (tick & ~holdFull)
                holdCnt <= holdCnt + 6'h01;
            if (startReq | ~inRun | blowerOn)
                pwdShift <= 6'h3f;
            else if (codeKey)
                pwdShift <= next_pwdShift;
            if (~tempOk | sbTimeout)
                tempSb <= 1'b0;
            else if (holdHit & inRun)
                tempSb <= ~tempSb;
            if (~tempSb | keyPress.blower)
            begin
                minCnt <= 10'h000;
                sbMin <= 8'h00;
            end
            else if (tick)
            begin
                minCnt <= minEnd ? 10'h000 : minCnt + 10'h001;
                if (minEnd)
                    sbMin <= sbMin + 8'h01;
            end
        end
    end

    // light and uv lamp
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            lightOn <= 1'b0;
            lightLockOff <= 1'b0;
            uvReq <= 1'b0;
        end
        else
        begin
            if (sbActive)
            begin
                lightOn <= 1'b0;
                if (lightOn)
                    lightLockOff <= 1'b1;
            end
            else
            begin
                lightLockOff <= 1'b0;
                if (inRun & keyPress.light)
                    lightOn <= ~lightOn;
            end
            if (~uvPermit)
                uvReq <= 1'b0;
            else if (inRun & keyPress.uv)
                uvReq <= ~uvReq;
        end
    end

    // alarm persistence and tone pattern
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            persistCnt <= 7'h00;
            alarmOn <= 1'b0;
            toneCnt <= 9'h000;
            repCnt <= 7'h00;
        end
        else
        begin
            if (~alarmCond)
                persistCnt <= 7'h00;
            else if (tick & ~alarmRaise)
                persistCnt <= persistCnt + 7'h01;
            // cleared only by the blower stopping or the monitor being disabled
            if (~blowerOn | opts[OPT_MONOFF])
                alarmOn <= 1'b0;
            else if (alarmRaise)
                alarmOn <= 1'b1;
            if (~alarmOn)
            begin
                toneCnt <= 9'h000;
                repCnt <= 7'h00;
            end
            else if (tick)
            begin
                if (toneCont)
                    toneCnt <= toneCnt + 9'h001;
                else
                    repCnt <= (repCnt == TONE_REP_TICKS - 7'h01) ? 7'h00 : repCnt + 7'h01;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            clickOn <= 1'b0;
            menuLed <= 1'b0;
            airflowBarDisplay <= '0;
            blowerLed <= 1'b0;
            lightLed <= 1'b0;
            blowerSlow <= 1'b0;
            uvOn <= 1'b0;
            fanRelay <= 1'b0;
            alarmRelay <= 1'b0;
            auxDcEn <= 1'b0;
            beeper <= 1'b0;
        end
        else
        begin
            // key click lasts until the next tick
            if (anyPress)
                clickOn <= 1'b1;
            else if (tick)
                clickOn <= 1'b0;
            menuLed <= inMenu & fastBlink;
            airflowBarDisplay <= inMenu ? menuSegs : runSegs;
            blowerLed <= next_blowerLed;
            lightLed <= lightLockOff ? fastBlink : lightOn;
            blowerSlow <= next_blowerSlow;
            uvOn <= uvReq & uvPermit;
            fanRelay <= blowerOn;
            alarmRelay <= alarmOn;
            auxDcEn <= blowerOn;
            beeper <= (toneReq | clickOn) & ~mute;
        end
    end
endmodule : com_ctrl
`default_nettype wire

// >>> test/com_panel.sv
// Purpose: keypad and window/airflow switch model
// Assumes: levels change just after a rising edge
// Notes: six-cycle presses so the synchroniser sees each one
`timescale 1ns/100ps
`default_nettype none
module com_panel
    import com_pkg::*;
(
    input wire logic clk_sys, // system clock
    output var com_keys_t keyPin, // key levels
    output var com_sense_t sensePin // switch levels
);
    initial
    begin
        keyPin = '0;
        sensePin = 5'h08;
    end
    task automatic hold(input int k, input logic v);
        @(posedge clk_sys);
        keyPin[k] <= v;
    endtask : hold
    task automatic hit(input int k);
        hold(k, 1'b1);
        repeat (6) @(posedge clk_sys);
        keyPin[k] <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : hit
    task automatic sense(input com_sense_t s);
        @(posedge clk_sys);
        sensePin <= s;
    endtask : sense
endmodule : com_panel
`default_nettype wire

// >>> test/com_ctrl_monitor.sv
// Purpose: port checks on the option menu controller
// Assumes: one clock, synchronous active-low reset
// Notes: relay checks lean on the one-cycle output stage
`timescale 1ns/100ps
`default_nettype none
module com_ctrl_monitor (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic blowerOn, // blower
    input wire logic blowerSlow, // setback speed
    input wire logic fanRelay, // fan
    input wire logic alarmRelay, // alarm
    input wire logic auxDcEn // aux dc
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    AST_APB_READY: assert property (setup_s |=> access_s)
        else $error("no ready after setup");
    AST_APB_PULSE: assert property (access_s |=> !pready)
        else $error("ready held too long");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_APB_RDATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    AST_FAN: assert property (fanRelay == $past(blowerOn))
        else $error("fan relay off blower");
    AST_AUX: assert property (auxDcEn == $past(blowerOn))
        else $error("aux output off blower");
    AST_ALARM: assert property ($rose(alarmRelay) |-> $past(blowerOn, 5))
        else $error("alarm without running blower");
    AST_SLOW: assert property ($rose(blowerSlow) |-> blowerOn)
        else $error("setback speed while stopped");
endmodule : com_ctrl_monitor
bind com_ctrl com_ctrl_monitor u_com_ctrl_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .blowerOn(blowerOn), .blowerSlow(blowerSlow), .fanRelay(fanRelay),
    .alarmRelay(alarmRelay), .auxDcEn(auxDcEn));
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench for the option menu controller
// Assumes: ten-clock tick, so one second is a hundred clocks
// Notes: register model in the bench gives expected values
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import com_pkg::*;
;
    localparam int TK = 10;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, v;
    logic menuLed, blowerLed, lightLed, blowerOn, blowerSlow, lightOn, uvOn;
    logic fanRelay, alarmRelay, auxDcEn, beeper;
    logic [NUM_OPT-1:0] airflowBarDisplay;
    com_keys_t keyPin;
    com_sense_t sensePin;
    int err_total = 0, total_checks = 0, cyc = 0, seed, i, q;
    int regM[$] = '{32'h0, 32'h4, 32'h1e};
    int msk[$] = '{32'h7f, 32'h3f, 32'hff};
    com_ctrl #(.TICK_CYCLES(TK)) u_com_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .keyPin(keyPin), .sensePin(sensePin),
        .menuLed(menuLed), .airflowBarDisplay(airflowBarDisplay), .blowerLed(blowerLed),
        .lightLed(lightLed), .blowerOn(blowerOn), .blowerSlow(blowerSlow), .lightOn(lightOn),
        .uvOn(uvOn), .fanRelay(fanRelay), .alarmRelay(alarmRelay), .auxDcEn(auxDcEn),
        .beeper(beeper));
    com_panel u_com_panel (.clk_sys(clk_sys), .keyPin(keyPin), .sensePin(sensePin));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic menu(input int sel, input logic on, input logic keep);
        int p, q, n;
        logic b;
        p = on ? regM[0] | (1 << sel) : regM[0] & ~(1 << sel);
        u_com_panel.hold(3, 1'b1);
        u_com_panel.hit(0);
        u_com_panel.hit(2);
        u_com_panel.hit(1);
        u_com_panel.hold(3, 1'b0);
        repeat (7) u_com_panel.hit(4);
        repeat (sel) u_com_panel.hit(3);
        u_com_panel.hit(on ? 2 : 1);
        q = 0;
        n = 0;
        b = airflowBarDisplay[sel];
        // watch long enough for two slow blink phases
        repeat (10 * TK)
        begin
            @(posedge clk_sys);
            q = q | (1 << menuLed);
            n += (airflowBarDisplay[sel] != b);
            b = airflowBarDisplay[sel];
        end
        chk("menu blink", 32'h3, q);
        chk("seg rate", 32'(on), 32'(n > 4));
        chk("segments", p & ~(1 << sel), airflowBarDisplay & ~(1 << sel));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("menu", 32'h1, rdat & 32'h1);
        chk("pending", p, (rdat >> 8) & 32'h7f);
        u_com_panel.hit(keep ? 0 : 5);
        if (keep)
            regM[0] = p;
        apb(1'b0, ADDR_OPT, 32'h0);
        chk("opt", regM[0], rdat);
        chk("menu led off", 32'h0, 32'(menuLed));
    endtask : menu
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst_n = 1'b0;
        seed = 81;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 3; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("reset value", regM[i], rdat);
            v = $random(seed);
            apb(1'b1, 12'(4 * i), v);
            regM[i] = v & msk[i];
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("readback", regM[i], rdat);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, 32'(rerr));
        apb(1'b1, ADDR_OPT, 32'h0);
        regM[0] = 0;
        u_com_panel.hit(6);
        chk("run", 32'h7, {29'h0, blowerOn, fanRelay, auxDcEn});
        u_com_panel.sense(5'h0c);
        repeat (95 * TK) @(posedge clk_sys);
        chk("alarm early", 32'h0, 32'(alarmRelay));
        repeat (10 * TK) @(posedge clk_sys);
        chk("alarm", 32'h1, 32'(alarmRelay));
        chk("tone", 32'h1, 32'(beeper));
        apb(1'b1, ADDR_OPT, 32'h10);
        repeat (4) @(posedge clk_sys);
        chk("monitor off", 32'h0, 32'(alarmRelay));
        u_com_panel.sense(5'h0a);
        repeat (105 * TK) @(posedge clk_sys);
        chk("monitor off high", 32'h0, 32'(alarmRelay));
        u_com_panel.sense(5'h08);
        apb(1'b1, ADDR_OPT, 32'h0);
        u_com_panel.hit(6);
        chk("stop", 32'h0, {29'h0, blowerOn, fanRelay, auxDcEn});
        menu(3, 1'b1, 1'b1);
        u_com_panel.hit(6);
        u_com_panel.hit(5);
        chk("light", 32'h1, 32'(lightOn));
        u_com_panel.sense(5'h10);
        q = 0;
        repeat (10 * TK)
        begin
            @(posedge clk_sys);
            q = q | (1 << lightLed) | (4 << blowerLed);
        end
        chk("setback blink", 32'hf, q);
        chk("setback", 32'h7, {29'h0, blowerOn, blowerSlow, fanRelay});
        chk("light locked", 32'h0, 32'(lightOn));
        u_com_panel.hit(4);
        chk("uv closed", 32'h1, 32'(uvOn));
        u_com_panel.sense(5'h08);
        repeat (6) @(posedge clk_sys);
        chk("uv raised", 32'h0, {30'h0, uvOn, blowerSlow});
        u_com_panel.hit(4);
        chk("uv blocked", 32'h0, 32'(uvOn));
        menu(3, 1'b0, 1'b1);
        menu(6, 1'b1, 1'b0);
        menu(1, 1'b1, 1'b1);
        u_com_panel.hit(4);
        chk("uv bypass", 32'h1, 32'(uvOn));
        u_com_panel.sense(5'h09);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3 * TK) @(posedge clk_sys);
        chk("auto restart", 32'h1, 32'(blowerOn));
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        // option must land before the first tick samples it
        apb(1'b1, ADDR_OPT, 32'h4);
        repeat (3 * TK) @(posedge clk_sys);
        chk("manual restart", 32'h0, 32'(blowerOn));
        u_com_panel.hit(6);
        chk("manual start", 32'h1, 32'(blowerOn));
        test_done();
    end
endmodule : tb_top
`default_nettype wire
